// ==== cif_core.sv ====
// interrupt enable, pending and error-condition registers with irq output
`timescale 1ns/1ps
module cif_core (
  input wire logic ref_clk,
  input wire logic reset,
  input wire cif_pkg::cif_reg_req_t req,
  output logic [7:0] rdata,
  input wire cif_pkg::cif_err_cnt_t cnt,
  input wire logic msg_fault_evt,
  input wire logic bus_activity_pin,
  input wire logic [2:0] tx_buf_empty_evt,
  input wire logic [1:0] rx_buf_full_evt,
  input wire logic [1:0] rx_overflow_evt,
  output logic irq_n
);
  logic [7:0] interrupt_enable_ff;
  logic [7:0] nxt_interrupt_enable;
  logic [7:0] interrupt_pending_ff;
  logic [7:0] nxt_interrupt_pending;
  logic [7:0] error_condition_ff;
  logic [7:0] nxt_error_condition;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic irq_n_ff;
  logic nxt_irq_n;
  logic wake_level;
  logic wake_prev_ff;
  logic [7:0] set_vec;
  logic [5:0] cond_now;
  logic bus_off_ff;
  logic nxt_bus_off;

  typedef enum logic [1:0] {
    CIF_BUS_ON = 2'b01,
    CIF_BUS_OFF = 2'b10
  } cif_bus_state_t;
  cif_bus_state_t bus_state_ff;
  cif_bus_state_t nxt_bus_state;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
    hit = req.wr && (a == t);
  endfunction

  cif_sync u_wake_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_in(bus_activity_pin),
    .level_out(wake_level)
  );

  // bus-off tracking
  always_comb begin
    nxt_bus_state = bus_state_ff;
    case (bus_state_ff)
      CIF_BUS_ON: begin
        if (cnt.tec == cif_pkg::BUSOFF_LIMIT) begin
          nxt_bus_state = CIF_BUS_OFF;
        end
      end
      CIF_BUS_OFF: begin
        if (cnt.bus_recovered) begin
          nxt_bus_state = CIF_BUS_ON;
        end
      end
      default: nxt_bus_state = CIF_BUS_ON;
    endcase
    nxt_bus_off = (nxt_bus_state == CIF_BUS_OFF);
  end

  // error-condition register
  always_comb begin
    cond_now = '0;
    cond_now[cif_pkg::EF_RXWARN] = cnt.rec >= cif_pkg::WARN_LIMIT;
    cond_now[cif_pkg::EF_TXWARN] = cnt.tec >= cif_pkg::WARN_LIMIT;
    cond_now[cif_pkg::EF_WARN] = cond_now[cif_pkg::EF_RXWARN] |
      cond_now[cif_pkg::EF_TXWARN];
    cond_now[cif_pkg::EF_RXPASS] = cnt.rec >= cif_pkg::PASSIVE_LIMIT;
    cond_now[cif_pkg::EF_TXPASS] = cnt.tec >= cif_pkg::PASSIVE_LIMIT;
    cond_now[cif_pkg::EF_BUSOFF] = nxt_bus_off;
    nxt_error_condition = error_condition_ff;
    nxt_error_condition[5:0] = cond_now;
    for (int i = 0; i < 2; i++) begin
      if (hit(req.addr, cif_pkg::ADDR_ERR_COND) &&
          req.wmask[cif_pkg::EF_RX0OV + i] &&
          !req.wdata[cif_pkg::EF_RX0OV + i]) begin
        nxt_error_condition[cif_pkg::EF_RX0OV + i] = 1'b0;
      end
      if (rx_buf_full_evt[i] &&
          interrupt_pending_ff[cif_pkg::BIT_RX0 + i]) begin
        nxt_error_condition[cif_pkg::EF_RX0OV + i] = 1'b1;
      end
    end
  end

  // interrupt sources and pending flags
  always_comb begin
    set_vec = '0;
    set_vec[cif_pkg::BIT_MSG] = msg_fault_evt;
    set_vec[cif_pkg::BIT_WAKE] = wake_level && !wake_prev_ff;
    set_vec[cif_pkg::BIT_ERR] =
      nxt_error_condition != error_condition_ff;
    set_vec[cif_pkg::BIT_TX2:cif_pkg::BIT_TX0] = tx_buf_empty_evt;
    set_vec[cif_pkg::BIT_RX1:cif_pkg::BIT_RX0] = rx_buf_full_evt;
    nxt_interrupt_enable = interrupt_enable_ff;
    nxt_interrupt_pending = interrupt_pending_ff;
    if (hit(req.addr, cif_pkg::ADDR_INT_ENABLE)) begin
      nxt_interrupt_enable = (interrupt_enable_ff & ~req.wmask) |
        (req.wdata & req.wmask);
    end
    if (hit(req.addr, cif_pkg::ADDR_INT_PENDING)) begin
      nxt_interrupt_pending = (interrupt_pending_ff & ~req.wmask) |
        (req.wdata & req.wmask);
    end
    nxt_interrupt_pending = nxt_interrupt_pending | set_vec;
    nxt_irq_n = ~|(nxt_interrupt_pending & nxt_interrupt_enable);
    case (req.addr)
      cif_pkg::ADDR_INT_ENABLE: nxt_rdata = nxt_interrupt_enable;
      cif_pkg::ADDR_INT_PENDING: nxt_rdata = nxt_interrupt_pending;
      cif_pkg::ADDR_ERR_COND: nxt_rdata = nxt_error_condition;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      interrupt_enable_ff <= cif_pkg::RST_INT_ENABLE;
      interrupt_pending_ff <= cif_pkg::RST_INT_PENDING;
      error_condition_ff <= cif_pkg::RST_ERR_COND;
      bus_state_ff <= CIF_BUS_ON;
      wake_prev_ff <= 1'b0;
      rdata_ff <= 8'h00;
      irq_n_ff <= 1'b1;
    end else begin
      interrupt_enable_ff <= nxt_interrupt_enable;
      interrupt_pending_ff <= nxt_interrupt_pending;
      error_condition_ff <= nxt_error_condition;
      bus_state_ff <= nxt_bus_state;
      wake_prev_ff <= wake_level;
      rdata_ff <= nxt_rdata;
      irq_n_ff <= nxt_irq_n;
    end
  end

  assign rdata = rdata_ff;
  assign irq_n = irq_n_ff;
endmodule

// ==== cif_pkg.sv ====
// package: register map, bit positions and carrier types
package cif_pkg;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h2B;
  localparam logic [7:0] ADDR_INT_PENDING = 8'h2C;
  localparam logic [7:0] ADDR_ERR_COND = 8'h2D;
  localparam logic [7:0] RST_INT_ENABLE = 8'h00;
  localparam logic [7:0] RST_INT_PENDING = 8'h00;
  localparam logic [7:0] RST_ERR_COND = 8'h00;
  localparam int BIT_RX0 = 0;
  localparam int BIT_RX1 = 1;
  localparam int BIT_TX0 = 2;
  localparam int BIT_TX1 = 3;
  localparam int BIT_TX2 = 4;
  localparam int BIT_ERR = 5;
  localparam int BIT_WAKE = 6;
  localparam int BIT_MSG = 7;
  localparam int EF_WARN = 0;
  localparam int EF_RXWARN = 1;
  localparam int EF_TXWARN = 2;
  localparam int EF_RXPASS = 3;
  localparam int EF_TXPASS = 4;
  localparam int EF_BUSOFF = 5;
  localparam int EF_RX0OV = 6;
  localparam int EF_RX1OV = 7;
  localparam logic [7:0] WARN_LIMIT = 8'h60;
  localparam logic [7:0] PASSIVE_LIMIT = 8'h80;
  localparam logic [7:0] BUSOFF_LIMIT = 8'hFF;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } cif_reg_req_t;

  typedef struct packed {
    logic [7:0] tec;
    logic [7:0] rec;
    logic bus_recovered;
  } cif_err_cnt_t;
endpackage

// ==== cif_sync.sv ====
// three-stage synchroniser for wake-up activity pin, with agreement filter
`timescale 1ns/1ps
module cif_sync (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic pin_in,
  output logic level_out
);
  logic [cif_pkg::SYNC_STAGES-1:0] stage_ff;
  logic [cif_pkg::SYNC_STAGES-1:0] nxt_stage;
  logic level_ff;
  logic nxt_level;

  always_comb begin
    nxt_stage = {stage_ff[cif_pkg::SYNC_STAGES-2:0], pin_in};
    nxt_level = level_ff;
    if (stage_ff[1] == stage_ff[2]) begin
      nxt_level = stage_ff[2];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stage_ff <= '0;
      level_ff <= 1'b0;
    end else begin
      stage_ff <= nxt_stage;
      level_ff <= nxt_level;
    end
  end

  assign level_out = level_ff;
endmodule

// ==== cif_host.sv ====
// host model issuing register reads and writes
`timescale 1ns/1ps
module cif_host (
  input wire logic ref_clk,
  input wire logic [7:0] rdata,
  output cif_pkg::cif_reg_req_t req
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, d, m);
    @(posedge ref_clk);
    #1 req = '{1'b1, a, d, m};
    @(posedge ref_clk);
    #1 req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge ref_clk);
    #1 req = '{1'b0, a, 8'h00, 8'h00};
    @(posedge ref_clk);
    #1 q = rdata;
  endtask
endmodule

// ==== cif_core_sva.sv ====
// assertions on the flag and enable core
`timescale 1ns/1ps
module cif_core_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire cif_pkg::cif_reg_req_t req,
  input wire logic [7:0] rdata,
  input wire cif_pkg::cif_err_cnt_t cnt,
  input wire logic [2:0] tx_buf_empty_evt,
  input wire logic [1:0] rx_buf_full_evt,
  input wire logic irq_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic en_a, pd_a, ef_a;
  assign en_a = req.addr == 8'h2B;
  assign pd_a = req.addr == 8'h2C;
  assign ef_a = req.addr == 8'h2D;
  sequence s_warn_rise;
    ($rose(cnt.tec >= 8'h60) && pd_a) ##1 pd_a [*2];
  endsequence
  AST_EN_WR: assert property (req.wr && en_a && req.wmask == 8'hFF
    |=> rdata == $past(req.wdata)) else $error("enable write lost");
  AST_RX_SET: assert property (|rx_buf_full_evt && pd_a |=>
    (rdata[1:0] & $past(rx_buf_full_evt)) == $past(rx_buf_full_evt))
    else $error("rx flag not set");
  AST_TX_SET: assert property (|tx_buf_empty_evt && pd_a |=>
    (rdata[4:2] & $past(tx_buf_empty_evt)) == $past(tx_buf_empty_evt))
    else $error("tx flag not set");
  AST_STICKY: assert property (pd_a && $past(pd_a) && !req.wr
    |=> ($past(rdata) & rdata) == $past(rdata)) else $error("flag lost");
  AST_IRQ_OFF: assert property (req.wr && en_a && req.wmask == 8'hFF
    && req.wdata == 8'h00 |=> irq_n) else $error("irq stuck");
  AST_WARN: assert property (ef_a |=> rdata[0] ==
    ($past(cnt.tec) >= 8'h60 || $past(cnt.rec) >= 8'h60))
    else $error("warning flag wrong");
  AST_LEVELS: assert property (ef_a |=> rdata[4:1] ==
    {$past(cnt.tec) >= 8'h80, $past(cnt.rec) >= 8'h80,
    $past(cnt.tec) >= 8'h60, $past(cnt.rec) >= 8'h60})
    else $error("level flags wrong");
  AST_BUSOFF: assert property (cnt.tec == 8'hFF && ef_a |=> rdata[5])
    else $error("bus-off not set");
  AST_ERR_PEND: assert property (s_warn_rise |-> ##[0:1] rdata[5])
    else $error("error pending not set");
endmodule
bind cif_core cif_core_chk chk_u (.ref_clk(ref_clk), .reset(reset),
  .req(req), .rdata(rdata), .cnt(cnt), .irq_n(irq_n),
  .tx_buf_empty_evt(tx_buf_empty_evt), .rx_buf_full_evt(rx_buf_full_evt));

// ==== tb_can_interrupt_flags_enables.sv ====
// testbench: reference flags and enables against the core
`timescale 1ns/1ps
module tb_can_interrupt_flags_enables;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  cif_pkg::cif_reg_req_t req;
  cif_pkg::cif_err_cnt_t cnt = '0;
  logic [7:0] rdata, en = 8'h00, pd = 8'h00, q, d, m;
  logic msg = 1'b0, pin = 1'b0, irq_n;
  logic [2:0] tx = 3'h0;
  logic [1:0] rx = 2'h0;
  int n_errors = 0, n_checks = 0, cyc = 0;
  always #12.5 ref_clk = ~ref_clk;
  cif_host host_u (.ref_clk(ref_clk), .rdata(rdata), .req(req));
  cif_core dut_u (.ref_clk(ref_clk), .reset(reset), .req(req),
    .rdata(rdata), .cnt(cnt), .msg_fault_evt(msg), .bus_activity_pin(pin),
    .tx_buf_empty_evt(tx), .rx_buf_full_evt(rx), .rx_overflow_evt(2'h0),
    .irq_n(irq_n));
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rc(string nm, logic [7:0] a, logic [7:0] e);
    host_u.rd(a, q);
    chk(nm, e, q);
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up;
    end
  end
  task automatic fire(logic [7:0] v);
    @(posedge ref_clk);
    #1 {msg, pin, tx, rx} = {v[7:6], v[4:0]};
    @(posedge ref_clk);
    #1 {msg, tx, rx} = '0;
    repeat (6) @(posedge ref_clk);
    #1 pin = 1'b0;
    pd = pd | v;
  endtask
  initial begin
    void'($urandom(32'h29eecb02));
    repeat (5) @(posedge ref_clk);
    #1 reset = 1'b0;
    rc("en", 8'h2B, 8'h00);
    rc("pd", 8'h2C, 8'h00);
    rc("ef", 8'h2D, 8'h00);
    rc("unmapped", 8'h3A, 8'h00);
    repeat (4) begin
      d = $urandom;
      m = $urandom;
      host_u.wr(8'h2B, d, m);
      en = (en & ~m) | (d & m);
      rc("en", 8'h2B, en);
    end
    for (int b = 0; b < 8; b++) begin
      if (b != 5) begin
        en = 8'h01 << b;
        host_u.wr(8'h2B, en, 8'hFF);
        host_u.rd(8'h2C, q);
        fire(en);
        rc("pd", 8'h2C, pd);
        chk("irq_n", 8'h00, {7'h00, irq_n});
        host_u.wr(8'h2C, 8'h00, en);
        pd = pd & ~en;
        rc("pd", 8'h2C, pd);
        chk("irq_n", 8'h01, {7'h00, irq_n});
      end
    end
    host_u.wr(8'h2B, 8'h20, 8'hFF);
    host_u.rd(8'h2C, q);
    cnt.tec = 8'h60;
    rc("pd", 8'h2C, 8'h20);
    rc("ef", 8'h2D, 8'h05);
    chk("irq_n", 8'h00, {7'h00, irq_n});
    cnt.tec = 8'hFF;
    rc("ef", 8'h2D, 8'h35);
    cnt.tec = 8'h00;
    rc("ef", 8'h2D, 8'h20);
    cnt.bus_recovered = 1'b1;
    @(posedge ref_clk);
    #1 cnt.bus_recovered = 1'b0;
    cnt.rec = 8'h80;
    rc("ef", 8'h2D, 8'h0B);
    wrap_up;
  end
endmodule
